/* pmc_pkg.sv */
// Contract
// - Power state field bits 13-12: 00 normal, 01 wake-frame, 10 energy; 11 reserved.
// - Any write to byte test register returns a reduced power state to normal.
// - Control register reads are answered even in a power saving state.
// - Writes are ignored after reset or wake until one read has occurred.
// - Writing one to bit 10 resets the PHY at least 100us, then self-clears.
// - Writes to the PHY reset bit are discarded while it reads high.
// - Remote wake enable bit 9 lets wake-frame events drive the enabled wake pin.
// - Remote wake enable lets wake-frame events raise the wake interrupt regardless of pin.
// - Energy enable bit 8 lets energy events drive the enabled wake pin.
// - Energy enable lets energy events raise the wake interrupt regardless of pin.
// - Bit 6 clear makes the wake pin open-drain, set makes it push-pull.
// - Open-drain wake pin ignores polarity and is always active low.
// - Bit 3 set pulses the wake pin for 50ms; clear holds it active.
// - Bit 1 enables the wake pin only; bit 2 set selects active high.
// - Read-only bit 0 shows the device is stable and may be accessed.
// - Bits 5-4 record wake cause, write-one-clear in normal state, deasserting pin.
package pmc_pkg;
    localparam int          ADDR_W            = 8;
    localparam int          DATA_W            = 32;
    localparam logic [7:0]  PSC_OFFSET        = 8'h84;
    localparam logic [7:0]  BYTE_TEST_OFFSET  = 8'h64;
    // Arbitrary fixed pattern
    localparam logic [31:0] BYTE_TEST_PATTERN = 32'h5a5a_c3c3;

    localparam int PS_LSB        = 12;
    localparam int TRANSCEIVER_RESET_REQUEST_BIT   = 10;
    localparam int WAKE_EN_BIT   = 9;
    localparam int ENERGY_EN_BIT = 8;
    localparam int BUF_TYPE_BIT  = 6;
    localparam int CAUSE_LSB     = 4;
    localparam int PULSE_SEL_BIT = 3;
    localparam int POL_BIT       = 2;
    localparam int PIN_EN_BIT    = 1;
    localparam int READY_BIT     = 0;

    localparam logic [1:0] PS_NORMAL   = 2'h0;
    localparam logic [1:0] PS_FRAME    = 2'h1;
    localparam logic [1:0] PS_ENERGY   = 2'h2;
    localparam logic [1:0] PS_RESERVED = 2'h3;

    localparam logic [1:0] PS_RESET    = 2'h0;
    localparam logic       EN_RESET    = 1'h0;
    localparam logic [1:0] CAUSE_RESET = 2'h0;

    localparam int CLK_PERIOD_NS   = 5;
    localparam int TRANSCEIVER_RESET_REQUEST_TIME_US = 100;
    localparam int PULSE_TIME_MS   = 50;
    localparam int SETTLE_TIME_NS  = 1000;
    localparam int TRANSCEIVER_RESET_REQUEST_CYCLES  =
        (TRANSCEIVER_RESET_REQUEST_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYCLES    = (PULSE_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int SETTLE_CYCLES   =
        (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* pmc_power_mgmt_control.sv */
`timescale 1ns/100ps
`default_nettype none
module pmc_power_mgmt_control
    import pmc_pkg::*;
#(
    parameter int PHY_RESET_CYCLES = TRANSCEIVER_RESET_REQUEST_CYCLES,
    parameter int WAKE_PULSE_CYCLES = PULSE_CYCLES,
    parameter int READY_SETTLE_CYCLES = SETTLE_CYCLES
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWrData,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic      [DATA_W-1:0] regRdData,
    // Wake event sources, asynchronous
    input  wire logic              wakeFrameEvent,
    input  wire logic              energySenseEvent,
    // Wake pin and interrupt
    output logic                   wakeEventOut,
    output logic                   wakeEventOe,
    output logic                   wakeInterrupt,
    // Power and PHY control
    output logic                   transceiverReset,
    output logic      [1:0]        powerStateSelect,
    output logic                   deviceReady
);
    // Control fields
    logic [1:0] powerState_q;
    logic       remoteWakeEnable_q;
    logic       energySenseEnable_q;
    logic       bufferType_q;
    logic       pulseSelect_q;
    logic       polarity_q;
    logic       pinEnable_q;
    logic [1:0] wakeCause_q;
    logic [1:0] wakeCause_d;

    // Access state
    logic       ready_q;
    logic       readSeen_q;
    logic       bootPending_q;
    logic [1:0] eventSync;
    logic [1:0] eventPrev_q;

    // Wake pin state
    logic       pinOut_q;
    logic       pinOe_q;
    logic       intr_q;

    // Timers
    logic       phyBusy;
    logic       pulseBusy;
    logic       settleBusy;

    // Decode
    wire hitCtrl     = (regAddr == PSC_OFFSET);
    wire hitByteTest = (regAddr == BYTE_TEST_OFFSET);
    wire inNormal    = (powerState_q == PS_NORMAL);

    wire writeOpen   = readSeen_q && ready_q;
    wire ctrlWrite   = regWrite && hitCtrl && writeOpen;
    wire wakeWrite   = regWrite && hitByteTest && !inNormal;

    wire [1:0] newState   = regWrData[PS_LSB+1:PS_LSB];
    wire       stateWrite = ctrlWrite && (newState != PS_RESERVED);
    wire       enterSleep = stateWrite && (newState != PS_NORMAL);

    wire phyStart = ctrlWrite && regWrData[TRANSCEIVER_RESET_REQUEST_BIT] && !phyBusy;

    // Event capture
    wire frameEdge  = eventSync[1] && !eventPrev_q[1];
    wire energyEdge = eventSync[0] && !eventPrev_q[0];
    wire frameHit   = frameEdge && remoteWakeEnable_q;
    wire energyHit  = energyEdge && energySenseEnable_q;
    wire [1:0] causeSet = {frameHit, energyHit};

    // Write-one-clear, normal state only
    wire [1:0] causeClr = (ctrlWrite && inNormal) ?
                          regWrData[CAUSE_LSB+1:CAUSE_LSB] : 2'h0;

    wire pulseStart = (causeSet != 2'h0);

    // Wake pin level
    wire causeLive = (wakeCause_q[1] && remoteWakeEnable_q) ||
                     (wakeCause_q[0] && energySenseEnable_q);
    wire pinActive = pinEnable_q && causeLive &&
                     (pulseSelect_q ? pulseBusy : 1'b1);
    wire pinOut_d  = bufferType_q ? (polarity_q ? pinActive : !pinActive)
                                  : 1'b0;
    wire pinOe_d   = bufferType_q ? 1'b1 : pinActive;

    wire ready_d   = inNormal && !settleBusy && !bootPending_q &&
                     !wakeWrite && !enterSleep;

    // Read data
    wire [DATA_W-1:0] ctrlView = {
        18'h0,
        powerState_q,
        1'b0,
        phyBusy,
        remoteWakeEnable_q,
        energySenseEnable_q,
        1'b0,
        bufferType_q,
        wakeCause_q,
        pulseSelect_q,
        polarity_q,
        pinEnable_q,
        ready_q
    };
    wire [DATA_W-1:0] rdMux = hitCtrl ? ctrlView :
                              (hitByteTest && ready_q) ? BYTE_TEST_PATTERN :
                              32'h0;

    assign wakeCause_d = (wakeCause_q & ~causeClr) | causeSet;

    pmc_sync2 #(
        .WIDTH(2)
    ) u_sync (
        .clk    (clk),
        .rst    (rst),
        .asyncIn({wakeFrameEvent, energySenseEvent}),
        .syncOut(eventSync)
    );

    pmc_timer #(
        .COUNT(PHY_RESET_CYCLES)
    ) u_phyTimer (
        .clk  (clk),
        .rst  (rst),
        .start(phyStart),
        .busy (phyBusy),
        .done ()
    );

    pmc_timer #(
        .COUNT(WAKE_PULSE_CYCLES)
    ) u_pulseTimer (
        .clk  (clk),
        .rst  (rst),
        .start(pulseStart),
        .busy (pulseBusy),
        .done ()
    );

    pmc_timer #(
        .COUNT(READY_SETTLE_CYCLES)
    ) u_settleTimer (
        .clk  (clk),
        .rst  (rst),
        .start(wakeWrite || bootPending_q),
        .busy (settleBusy),
        .done ()
    );

    // Power state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            powerState_q <= PS_RESET;
        end else if (wakeWrite) begin
            powerState_q <= PS_NORMAL;
        end else if (stateWrite) begin
            powerState_q <= newState;
        end
    end

    // Enables and pin configuration
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            remoteWakeEnable_q  <= EN_RESET;
            energySenseEnable_q <= EN_RESET;
            bufferType_q        <= EN_RESET;
            pulseSelect_q       <= EN_RESET;
            polarity_q          <= EN_RESET;
            pinEnable_q         <= EN_RESET;
        end else if (ctrlWrite) begin
            remoteWakeEnable_q  <= regWrData[WAKE_EN_BIT];
            energySenseEnable_q <= regWrData[ENERGY_EN_BIT];
            bufferType_q        <= regWrData[BUF_TYPE_BIT];
            pulseSelect_q       <= regWrData[PULSE_SEL_BIT];
            polarity_q          <= regWrData[POL_BIT];
            pinEnable_q         <= regWrData[PIN_EN_BIT];
        end
    end

    // Wake cause and events
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wakeCause_q <= CAUSE_RESET;
            eventPrev_q <= 2'h0;
            intr_q      <= 1'b0;
        end else begin
            wakeCause_q <= wakeCause_d;
            eventPrev_q <= eventSync;
            intr_q      <= (wakeCause_d != 2'h0);
        end
    end

    // Access gating
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readSeen_q    <= 1'b0;
            bootPending_q <= 1'b1;
            ready_q       <= 1'b0;
        end else begin
            bootPending_q <= 1'b0;
            ready_q       <= ready_d;
            if (wakeWrite) begin
                readSeen_q <= 1'b0;
            end else if (regRead) begin
                readSeen_q <= 1'b1;
            end
        end
    end

    // Pin and read data registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinOut_q  <= 1'b0;
            pinOe_q   <= 1'b0;
            regRdData <= '0;
        end else begin
            pinOut_q  <= pinOut_d;
            pinOe_q   <= pinOe_d;
            regRdData <= regRead ? rdMux : '0;
        end
    end

    assign wakeEventOut     = pinOut_q;
    assign wakeEventOe      = pinOe_q;
    assign wakeInterrupt    = intr_q;
    assign transceiverReset = phyBusy;
    assign powerStateSelect = powerState_q;
    assign deviceReady      = ready_q;
endmodule
`default_nettype wire

/* pmc_power_mgmt_control_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module pmc_power_mgmt_control_monitor
    import pmc_pkg::*;
#(
    parameter int PHY_RESET_CYCLES    = TRANSCEIVER_RESET_REQUEST_CYCLES,
    parameter int READY_SETTLE_CYCLES = SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic              regWrite,
    input wire logic              regRead,
    input wire logic [DATA_W-1:0] regRdData,
    // Events, pin and interrupt
    input wire logic              wakeFrameEvent,
    input wire logic              energySenseEvent,
    input wire logic              wakeEventOut,
    input wire logic              wakeEventOe,
    input wire logic              wakeInterrupt,
    // Power control
    input wire logic              transceiverReset,
    input wire logic [1:0]        powerStateSelect,
    input wire logic              deviceReady
);
    localparam int WAKE_MAX = READY_SETTLE_CYCLES + 4;

    logic [15:0] rstCnt_q;
    logic        anyRead_q;
    logic        readSeen_q;
    logic        pscRead_q;
    logic        drainKnown_q;
    wire         ctlWr = regWrite && regAddr == PSC_OFFSET;

    // Open-drain mode as last read back, forgotten on any control write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rstCnt_q     <= '0;
            anyRead_q    <= 1'b0;
            readSeen_q   <= 1'b0;
            pscRead_q    <= 1'b0;
            drainKnown_q <= 1'b0;
        end else begin
            rstCnt_q     <= transceiverReset ? rstCnt_q + 16'h1 : 16'h0;
            anyRead_q    <= anyRead_q | regRead;
            readSeen_q   <= deviceReady & (readSeen_q | regRead);
            pscRead_q    <= regRead && regAddr == PSC_OFFSET;
            drainKnown_q <= !ctlWr &&
                            (pscRead_q ? !regRdData[BUF_TYPE_BIT] : drainKnown_q);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Back in normal state, then ready after settling
    sequence wake_seq;
        powerStateSelect == PS_NORMAL && !deviceReady ##[1:WAKE_MAX] deviceReady;
    endsequence

    a_state_legal: assert property (powerStateSelect != PS_RESERVED)
        else $error("reserved power state");
    a_read_answer: assert property (regRead && regAddr == PSC_OFFSET |=>
        regRdData[13:12] == $past(powerStateSelect) && regRdData[0] == $past(deviceReady))
        else $error("control read mismatch");
    a_phy_start: assert property (ctlWr && regWrData[TRANSCEIVER_RESET_REQUEST_BIT] && !transceiverReset
        && readSeen_q && deviceReady |=> transceiverReset)
        else $error("phy reset not started");
    a_phy_hold: assert property ($fell(transceiverReset) |-> rstCnt_q >= PHY_RESET_CYCLES)
        else $error("phy reset too short");
    a_phy_bound: assert property (rstCnt_q <= PHY_RESET_CYCLES + 2)
        else $error("phy reset too long");
    a_write_locked: assert property (ctlWr && !anyRead_q |=>
        !transceiverReset && $stable(powerStateSelect))
        else $error("write taken before read");
    a_wake_resume: assert property (regWrite && regAddr == BYTE_TEST_OFFSET
        && powerStateSelect != PS_NORMAL |=> wake_seq)
        else $error("no wake on byte test write");
    a_ready_sleep: assert property (powerStateSelect != PS_NORMAL |=> !deviceReady)
        else $error("ready while sleeping");
    a_irq_source: assert property ($rose(wakeInterrupt) |-> wakeFrameEvent || energySenseEvent)
        else $error("interrupt without event");
    a_od_low: assert property (drainKnown_q && wakeEventOe |-> !wakeEventOut)
        else $error("wake pin driven high");
endmodule
`default_nettype wire

/* pmc_sync2.sv */
`timescale 1ns/100ps
`default_nettype none
module pmc_sync2 #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Data
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;

    generate
        if (WIDTH < 1) begin : g_chk
            $error("pmc_sync2: WIDTH must be at least 1");
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q  <= '0;
            syncOut <= '0;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* pmc_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module pmc_timer #(
    parameter int COUNT = 20000
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LOAD = CW'(COUNT);
    localparam logic [CW-1:0] ONE  = CW'(1);

    logic [CW-1:0] cnt_q;

    generate
        if (COUNT < 1) begin : g_chk
            $error("pmc_timer: COUNT must be at least 1");
        end
    endgenerate

    assign busy = (cnt_q != '0);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            done  <= 1'b0;
        end else begin
            done <= (cnt_q == ONE) && !start;
            if (start) begin
                cnt_q <= LOAD;
            end else if (busy) begin
                cnt_q <= cnt_q - ONE;
            end
        end
    end
endmodule
`default_nettype wire

/* pmc_wake_source.sv */
`timescale 1ns/100ps
`default_nettype none
module pmc_wake_source #(
    parameter int HOLD = 12
) (
    // Clock and requests
    input wire logic clk,
    input wire logic frameReq,
    input wire logic energyReq,
    // Wake pin
    input wire logic wakeEventOut,
    input wire logic wakeEventOe,
    output logic     wakeLine,
    // Event levels
    output logic     wakeFrameEvent,
    output logic     energySenseEvent
);
    int frameCnt  = 0;
    int energyCnt = 0;
    // Pull-up holds the line high when not driven
    assign wakeLine         = wakeEventOe ? wakeEventOut : 1'b1;
    assign wakeFrameEvent   = frameCnt != 0;
    assign energySenseEvent = energyCnt != 0;
    always @(posedge clk) begin
        frameCnt  <= frameReq ? HOLD : (frameCnt != 0 ? frameCnt - 1 : 0);
        energyCnt <= energyReq ? HOLD : (energyCnt != 0 ? energyCnt - 1 : 0);
    end
endmodule
`default_nettype wire

/* power_mgmt_control_test.sv */
`timescale 1ns/100ps
`default_nettype none
module power_mgmt_control_test
    import pmc_pkg::*;
;
    localparam int PHY_N   = 20;
    localparam int PULSE_N = 30;
    logic        clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic        frameReq = 1'b0, energyReq = 1'b0;
    logic [7:0]  regAddr = '0;
    logic [31:0] regWrData = '0, regRdData;
    logic [1:0]  powerStateSelect;
    logic        wakeEventOut, wakeEventOe, wakeInterrupt, transceiverReset;
    logic        deviceReady, wakeLine, wakeFrameEvent, energySenseEvent;
    int          fail_count = 0, n_checks = 0, n;

    always #2.5 clk = ~clk;

    pmc_power_mgmt_control #(
        .PHY_RESET_CYCLES(PHY_N), .WAKE_PULSE_CYCLES(PULSE_N), .READY_SETTLE_CYCLES(5)
    ) pmc_power_mgmt_control_i (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .wakeFrameEvent(wakeFrameEvent), .energySenseEvent(energySenseEvent),
        .wakeEventOut(wakeEventOut), .wakeEventOe(wakeEventOe),
        .wakeInterrupt(wakeInterrupt), .transceiverReset(transceiverReset),
        .powerStateSelect(powerStateSelect), .deviceReady(deviceReady));
    pmc_wake_source pmc_wake_source_i (
        .clk(clk), .frameReq(frameReq), .energyReq(energyReq), .wakeEventOut(wakeEventOut),
        .wakeEventOe(wakeEventOe), .wakeLine(wakeLine), .wakeFrameEvent(wakeFrameEvent),
        .energySenseEvent(energySenseEvent));

    task automatic close_out();
        $display("checks %0d failures %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic give_up();
        chk(32'h0, 32'h1, "timeout");
        close_out();
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge clk);
        regWrite  <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        chk(regRdData, exp, what);
    endtask

    task automatic fire(input logic frame);
        @(posedge clk);
        frameReq  <= frame;
        energyReq <= !frame;
        @(posedge clk);
        frameReq  <= 1'b0;
        energyReq <= 1'b0;
    endtask

    task automatic wait_ready();
        for (int i = 0; deviceReady !== 1'b1; i++) begin
            if (i == 100) give_up();
            @(posedge clk);
        end
        #1;
    endtask

    task automatic count_run(input bit pin, input logic lvl);
        n = 0;
        #1;
        while ((pin ? wakeLine : transceiverReset) === lvl) begin
            n++;
            if (n == 200) give_up();
            settle(1);
        end
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        wait_ready();
        wr(PSC_OFFSET, 32'h0000_0206);
        rd(PSC_OFFSET, 32'h0000_0001, "reset value");
        rd(8'h10, 32'h0, "unmapped");
        wr(PSC_OFFSET, 32'h0000_3002);
        rd(PSC_OFFSET, 32'h0000_0003, "reserved state");
        wr(PSC_OFFSET, 32'h0000_0400);
        rd(PSC_OFFSET, 32'h0000_0401, "phy busy");
        wr(PSC_OFFSET, 32'h0000_0400);
        count_run(1'b0, 1'b1);
        chk(32'(n >= PHY_N - 5 && n <= PHY_N - 3), 32'h1, "phy length");
        rd(PSC_OFFSET, 32'h0000_0001, "phy cleared");
        rd(BYTE_TEST_OFFSET, BYTE_TEST_PATTERN, "byte test");
        wr(PSC_OFFSET, 32'h0000_020e);
        fire(1'b0);
        settle(10);
        chk(32'(wakeInterrupt), 32'h0, "energy off");
        fire(1'b1);
        settle(6);
        chk(32'(wakeInterrupt), 32'h1, "frame irq");
        chk(32'(wakeLine), 32'h0, "drain pulse");
        rd(PSC_OFFSET, 32'h0000_022f, "frame cause");
        count_run(1'b1, 1'b0);
        chk(32'(n >= PULSE_N - 10 && n <= PULSE_N - 2), 32'h1, "pulse");
        chk(32'(wakeInterrupt), 32'h1, "irq holds");
        wr(PSC_OFFSET, 32'h0000_022e);
        settle(3);
        chk(32'(wakeInterrupt), 32'h0, "cause cleared");
        chk(32'(wakeLine), 32'h1, "drain idle");
        wr(PSC_OFFSET, 32'h0000_0146);
        fire(1'b0);
        settle(50);
        chk(32'(wakeLine), 32'h1, "static high");
        chk(32'(wakeInterrupt), 32'h1, "energy irq");
        rd(PSC_OFFSET, 32'h0000_0157, "energy cause");
        wr(PSC_OFFSET, 32'h0000_0144);
        settle(3);
        chk(32'(wakeLine), 32'h0, "pin off");
        chk(32'(wakeInterrupt), 32'h1, "irq kept");
        for (int s = 1; s < 3; s++) begin
            wr(PSC_OFFSET, {18'h0, 2'(s), 12'h010});
            settle(3);
            chk(32'(powerStateSelect), 32'(s), "state");
            rd(PSC_OFFSET, {18'h0, 2'(s), 12'h0}, "sleep read");
            wr(BYTE_TEST_OFFSET, 32'h0);
            wait_ready();
            chk(32'(powerStateSelect), 32'h0, "woke");
            wr(PSC_OFFSET, 32'h2);
            rd(PSC_OFFSET, 32'h1, "locked");
            wr(PSC_OFFSET, 32'h2);
            rd(PSC_OFFSET, 32'h3, "unlocked");
        end
        close_out();
    end
endmodule

bind pmc_power_mgmt_control pmc_power_mgmt_control_monitor #(
    .PHY_RESET_CYCLES(PHY_RESET_CYCLES), .READY_SETTLE_CYCLES(READY_SETTLE_CYCLES)
) pmc_power_mgmt_control_monitor_i (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .wakeFrameEvent(wakeFrameEvent),
    .energySenseEvent(energySenseEvent), .wakeEventOut(wakeEventOut),
    .wakeEventOe(wakeEventOe), .wakeInterrupt(wakeInterrupt),
    .transceiverReset(transceiverReset), .powerStateSelect(powerStateSelect),
    .deviceReady(deviceReady));
`default_nettype wire
